// [hw/tcpm_consts.svh]
// constants of the two-cell protector and measurement block
// assumes a 100 MHz time base and comparator inputs from the analog front end
// Operation
// - Either cell above high threshold past high delay turns charge gate off.
// - Discharge gate stays on during a high-voltage fault.
// - High-voltage fault clears when both cells drop below charge-resume threshold.
// - Also clears on sustained discharge of at least 1.2mV with both cells below high.
// - Either cell below low threshold past low delay turns both gates off.
// - Low-voltage fault requests sleep only when the sleep enable bit is 1.
// - Charger present and both cells in 0..resume enables recovery charge path.
// - After low-voltage fault both gates stay off until both cells exceed low and, with sleep enabled, a charger is present.
// - Sense below charge overcurrent threshold past overcurrent delay turns both gates off.
// - Charge overcurrent enables pack pulldown; clears when pack drops below supply margin.
// - Sense above discharge overcurrent threshold past overcurrent delay turns discharge off.
// - Sense above short-circuit threshold past short delay turns discharge off.
// - Discharge faults enable pack pullup; clear when pack rises above supply margin.
// - Charge gate on only with no high, low, charge-overcurrent fault and block 0.
// - Discharge gate on only with no low, overcurrent, short fault and block 0.
// - Protection inputs are monitored continuously while active.
// - Lower and upper cell voltages measured every 440ms.
// - Voltages two's complement, 4.8828mV steps, saturate high at 7FE0h.
// - Temperature updated every 440ms, two's complement, 0.125C steps.
// - Current result updated every 3.52s, 1.5625uV per step.
// - Current saturates to 7FFFh high and 8000h low.
// - Every 28.16s the averaged current becomes the mean of eight latest currents.
`ifndef TCPM_CONSTS_SVH
`define TCPM_CONSTS_SVH

`define TCPM_CLK_MHZ 100
`define TCPM_MEAS_MS 440
`define TCPM_CUR_MS 3520
`define TCPM_AVG_MS 28160
`define TCPM_MEAS_CYC (`TCPM_MEAS_MS * 1000 * `TCPM_CLK_MHZ)
`define TCPM_CUR_PER_MEAS (`TCPM_CUR_MS / `TCPM_MEAS_MS)
`define TCPM_AVG_PER_CUR (`TCPM_AVG_MS / `TCPM_CUR_MS)

`define TCPM_HV_DELAY_US 1000000
`define TCPM_LV_DELAY_US 1000000
`define TCPM_OC_DELAY_US 10000
`define TCPM_SC_DELAY_US 100
`define TCPM_HV_DELAY_CYC (`TCPM_HV_DELAY_US * `TCPM_CLK_MHZ)
`define TCPM_LV_DELAY_CYC (`TCPM_LV_DELAY_US * `TCPM_CLK_MHZ)
`define TCPM_OC_DELAY_CYC (`TCPM_OC_DELAY_US * `TCPM_CLK_MHZ)
`define TCPM_SC_DELAY_CYC (`TCPM_SC_DELAY_US * `TCPM_CLK_MHZ)

`define TCPM_CMP_N 12
`define TCPM_CMP_CELL_HIGH 0
`define TCPM_CMP_CELL_LOW 1
`define TCPM_CMP_BOTH_ABOVE_LOW 2
`define TCPM_CMP_BOTH_BELOW_RESUME 3
`define TCPM_CMP_BOTH_NONNEG 4
`define TCPM_CMP_DSG_SENSE 5
`define TCPM_CMP_COC 6
`define TCPM_CMP_DOC 7
`define TCPM_CMP_SC 8
`define TCPM_CMP_CHARGER 9
`define TCPM_CMP_PACK_LOW 10
`define TCPM_CMP_PACK_HIGH 11

`define TCPM_VOLT_MAX 13'sh03FF
`define TCPM_VOLT_MIN 13'sh1C00
`define TCPM_VOLT_SAT_HI 16'h7FE0
`define TCPM_VOLT_SAT_LO 16'h8000
`define TCPM_CUR_MAX 18'sh07FFF
`define TCPM_CUR_MIN 18'sh38000
`define TCPM_CUR_SAT_HI 16'h7FFF
`define TCPM_CUR_SAT_LO 16'h8000
`define TCPM_FIELD_PAD 5'h00
`define TCPM_AVG_DEPTH 8
`define TCPM_AVG_SHIFT 3
`define TCPM_AVG_CUR_OFFSET 8'h08
`define TCPM_RESULT_RESET 16'h0000

`endif

// [hw/tcpm_pkg.sv]
// types shared by the protector and measurement modules
// assumes tcpm_consts.svh is on the include path
`include "tcpm_consts.svh"
package tcpm_pkg;
  typedef logic [15:0] tcpm_word_t;
  typedef logic [`TCPM_CMP_N-1:0] tcpm_cmp_t;
  typedef logic signed [12:0] tcpm_volt_raw_t;
  typedef logic signed [10:0] tcpm_temp_raw_t;
  typedef logic signed [17:0] tcpm_cur_raw_t;
endpackage

// [hw/tcpm_cmp_if.sv]
// synchronised comparator levels passed from the pin synchroniser
// assumes one clock domain on both ends
`timescale 1ns/100ps
interface tcpm_cmp_if;
  tcpm_pkg::tcpm_cmp_t level;
  modport drv (output level);
  modport mon (input level);
endinterface

// [hw/tcpm_pin_sync.sv]
// two-flop synchroniser for the comparator pins
// assumes asynchronous comparator outputs from the analog front end
`timescale 1ns/100ps
`include "tcpm_consts.svh"
module tcpm_pin_sync (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // raw comparator pins
  input wire tcpm_pkg::tcpm_cmp_t cmp_pins_in,
  // synchronised levels
  tcpm_cmp_if.drv cmp_out
);
  import tcpm_pkg::*;
  genvar i;
  generate
    for (i = 0; i < `TCPM_CMP_N; i++) begin : g_bit
      logic meta;
      logic stable;
      always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= cmp_pins_in[i];
          stable <= meta;
        end
      end
      assign cmp_out.level[i] = stable;
    end
  endgenerate
endmodule

// [hw/tcpm_qualify.sv]
// fault qualification timer: level high once the condition held past the delay
// assumes a synchronised condition on the same clock
`timescale 1ns/100ps
module tcpm_qualify #(
  parameter int unsigned DELAY_CYC = 1
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // condition and result
  input wire logic cond_in,
  output logic qualified_out
);
  import tcpm_pkg::*;
  logic [31:0] count;
  // strictly longer than the delay: the count must reach it and the condition hold one more cycle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count <= 32'h00000000;
      qualified_out <= 1'b0;
    end else if (!cond_in) begin
      count <= 32'h00000000;
      qualified_out <= 1'b0;
    end else if (count < DELAY_CYC) begin
      count <= count + 32'h00000001;
      qualified_out <= 1'b0;
    end else begin
      qualified_out <= 1'b1;
    end
  end
endmodule

// [hw/tcpm_protector.sv]
// two-cell protector with measurement result formatting
// assumes comparator pins from the front end and conversion data on this clock
`timescale 1ns/100ps
`include "tcpm_consts.svh"
module tcpm_protector #(
  parameter int unsigned MEAS_CYC = `TCPM_MEAS_CYC,
  parameter int unsigned HV_DELAY_CYC = `TCPM_HV_DELAY_CYC,
  parameter int unsigned LV_DELAY_CYC = `TCPM_LV_DELAY_CYC,
  parameter int unsigned OC_DELAY_CYC = `TCPM_OC_DELAY_CYC,
  parameter int unsigned SC_DELAY_CYC = `TCPM_SC_DELAY_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // comparator pins
  input wire tcpm_pkg::tcpm_cmp_t cmp_pins_in,
  // software control bits
  input wire logic low_voltage_sleep_enable_in,
  input wire logic charge_gate_block_in,
  input wire logic discharge_gate_block_in,
  // converter data
  input wire tcpm_pkg::tcpm_volt_raw_t lower_cell_tap_raw_in,
  input wire tcpm_pkg::tcpm_volt_raw_t upper_cell_tap_raw_in,
  input wire tcpm_pkg::tcpm_temp_raw_t temperature_raw_in,
  input wire tcpm_pkg::tcpm_cur_raw_t current_sense_input_raw_in,
  // gate and pack controls
  output logic charge_fet_gate_out,
  output logic discharge_fet_gate_out,
  output logic recovery_charge_current_en_out,
  output logic pack_pulldown_test_current_en_out,
  output logic pack_pullup_test_current_en_out,
  output logic sleep_request_out,
  // fault status
  output logic cell_high_voltage_fault_out,
  output logic cell_low_voltage_fault_out,
  output logic charge_overcurrent_fault_out,
  output logic discharge_overcurrent_fault_out,
  output logic short_circuit_fault_out,
  // measurement results
  output tcpm_pkg::tcpm_word_t lower_cell_voltage_result_out,
  output tcpm_pkg::tcpm_word_t upper_cell_voltage_result_out,
  output tcpm_pkg::tcpm_word_t temperature_result_out,
  output tcpm_pkg::tcpm_word_t current_result_out,
  output tcpm_pkg::tcpm_word_t average_current_result_out,
  output logic current_updated_out,
  output logic average_updated_out
);
  import tcpm_pkg::*;

  tcpm_cmp_if cmp ();
  logic hv_fault;
  logic lv_fault;
  logic coc_fault;
  logic doc_fault;
  logic sc_fault;
  logic active;
  logic qual_hv;
  logic qual_lv;
  logic qual_coc;
  logic qual_doc;
  logic qual_sc;
  logic hv_release;
  logic lv_release;
  logic charger;
  logic cell_high;
  logic next_charge_gate;
  logic next_discharge_gate;

  tcpm_pin_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .cmp_pins_in(cmp_pins_in),
    .cmp_out(cmp.drv)
  );

  assign charger = cmp.level[`TCPM_CMP_CHARGER];
  assign cell_high = cmp.level[`TCPM_CMP_CELL_HIGH];
  // monitoring stops only once sleep has been requested
  assign active = !sleep_request_out;

  tcpm_qualify #(.DELAY_CYC(HV_DELAY_CYC)) u_q_hv (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .cond_in(active && cell_high),
    .qualified_out(qual_hv)
  );
  tcpm_qualify #(.DELAY_CYC(LV_DELAY_CYC)) u_q_lv (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .cond_in(active && cmp.level[`TCPM_CMP_CELL_LOW]),
    .qualified_out(qual_lv)
  );
  tcpm_qualify #(.DELAY_CYC(OC_DELAY_CYC)) u_q_coc (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .cond_in(active && cmp.level[`TCPM_CMP_COC]),
    .qualified_out(qual_coc)
  );
  tcpm_qualify #(.DELAY_CYC(OC_DELAY_CYC)) u_q_doc (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .cond_in(active && cmp.level[`TCPM_CMP_DOC]),
    .qualified_out(qual_doc)
  );
  tcpm_qualify #(.DELAY_CYC(SC_DELAY_CYC)) u_q_sc (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .cond_in(active && cmp.level[`TCPM_CMP_SC]),
    .qualified_out(qual_sc)
  );

  // releases; a qualifying set always wins over a release
  assign hv_release = cmp.level[`TCPM_CMP_BOTH_BELOW_RESUME]
    || (cmp.level[`TCPM_CMP_DSG_SENSE] && !cell_high);
  // charger only releases once the cells are back above low
  assign lv_release = cmp.level[`TCPM_CMP_BOTH_ABOVE_LOW]
    && (charger || !low_voltage_sleep_enable_in);

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hv_fault <= 1'b0;
    end else if (qual_hv) begin
      hv_fault <= 1'b1;
    end else if (hv_release) begin
      hv_fault <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lv_fault <= 1'b0;
    end else if (qual_lv) begin
      lv_fault <= 1'b1;
    end else if (lv_release) begin
      lv_fault <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      coc_fault <= 1'b0;
    end else if (qual_coc) begin
      coc_fault <= 1'b1;
    end else if (cmp.level[`TCPM_CMP_PACK_LOW]) begin
      coc_fault <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      doc_fault <= 1'b0;
      sc_fault <= 1'b0;
    end else begin
      if (qual_doc) begin
        doc_fault <= 1'b1;
      end else if (cmp.level[`TCPM_CMP_PACK_HIGH]) begin
        doc_fault <= 1'b0;
      end
      if (qual_sc) begin
        sc_fault <= 1'b1;
      end else if (cmp.level[`TCPM_CMP_PACK_HIGH]) begin
        sc_fault <= 1'b0;
      end
    end
  end

  always_comb begin
    next_charge_gate = active && !hv_fault && !lv_fault && !coc_fault
      && !charge_gate_block_in;
    // no high-voltage term: discharging stays possible
    next_discharge_gate = active && !lv_fault && !coc_fault && !doc_fault
      && !sc_fault && !discharge_gate_block_in;
  end

  // gates and pack test currents are registered; they lag the faults by one cycle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      charge_fet_gate_out <= 1'b0;
      discharge_fet_gate_out <= 1'b0;
      pack_pulldown_test_current_en_out <= 1'b0;
      pack_pullup_test_current_en_out <= 1'b0;
      recovery_charge_current_en_out <= 1'b0;
    end else begin
      charge_fet_gate_out <= next_charge_gate;
      discharge_fet_gate_out <= next_discharge_gate;
      pack_pulldown_test_current_en_out <= coc_fault;
      pack_pullup_test_current_en_out <= doc_fault || sc_fault;
      recovery_charge_current_en_out <= charger
        && cmp.level[`TCPM_CMP_BOTH_NONNEG] && cmp.level[`TCPM_CMP_BOTH_BELOW_RESUME];
    end
  end

  // sleep is never entered with a charger attached
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sleep_request_out <= 1'b0;
    end else begin
      sleep_request_out <= lv_fault && low_voltage_sleep_enable_in && !charger;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cell_high_voltage_fault_out <= 1'b0;
      cell_low_voltage_fault_out <= 1'b0;
      charge_overcurrent_fault_out <= 1'b0;
      discharge_overcurrent_fault_out <= 1'b0;
      short_circuit_fault_out <= 1'b0;
    end else begin
      cell_high_voltage_fault_out <= hv_fault;
      cell_low_voltage_fault_out <= lv_fault;
      charge_overcurrent_fault_out <= coc_fault;
      discharge_overcurrent_fault_out <= doc_fault;
      short_circuit_fault_out <= sc_fault;
    end
  end

  // measurement time base
  logic [31:0] meas_cnt;
  logic meas_tick;
  logic [2:0] cur_cnt;
  logic [2:0] avg_cnt;
  logic cur_tick;
  logic avg_due;

  assign meas_tick = active && (meas_cnt == MEAS_CYC - 1);
  assign cur_tick = meas_tick && (cur_cnt == 3'(`TCPM_CUR_PER_MEAS - 1));

  // the time base holds while sleeping, so results keep their last values
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meas_cnt <= 32'h00000000;
      cur_cnt <= 3'h0;
      avg_cnt <= 3'h0;
    end else if (active) begin
      meas_cnt <= meas_tick ? 32'h00000000 : meas_cnt + 32'h00000001;
      if (meas_tick) begin
        cur_cnt <= cur_tick ? 3'h0 : cur_cnt + 3'h1;
      end
      if (cur_tick) begin
        avg_cnt <= (avg_cnt == 3'(`TCPM_AVG_PER_CUR - 1)) ? 3'h0 : avg_cnt + 3'h1;
      end
    end
  end

  function automatic tcpm_word_t sat_volt(input tcpm_volt_raw_t v);
    if (v > `TCPM_VOLT_MAX) begin
      return `TCPM_VOLT_SAT_HI;
    end else if (v < signed'(`TCPM_VOLT_MIN)) begin
      return `TCPM_VOLT_SAT_LO;
    end
    return {v[10:0], `TCPM_FIELD_PAD};
  endfunction

  function automatic tcpm_word_t sat_cur(input tcpm_cur_raw_t c);
    if (c > `TCPM_CUR_MAX) begin
      return `TCPM_CUR_SAT_HI;
    end else if (c < signed'(`TCPM_CUR_MIN)) begin
      return `TCPM_CUR_SAT_LO;
    end
    return c[15:0];
  endfunction

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lower_cell_voltage_result_out <= `TCPM_RESULT_RESET;
      upper_cell_voltage_result_out <= `TCPM_RESULT_RESET;
      temperature_result_out <= `TCPM_RESULT_RESET;
    end else if (meas_tick) begin
      lower_cell_voltage_result_out <= sat_volt(lower_cell_tap_raw_in);
      upper_cell_voltage_result_out <= sat_volt(upper_cell_tap_raw_in);
      temperature_result_out <= {temperature_raw_in, `TCPM_FIELD_PAD};
    end
  end

  // eight most recent currents, written round-robin
  tcpm_word_t hist [`TCPM_AVG_DEPTH];
  logic [2:0] wr_idx;
  logic signed [18:0] hist_sum;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      current_result_out <= `TCPM_RESULT_RESET;
      current_updated_out <= 1'b0;
      wr_idx <= 3'h0;
      for (int i = 0; i < `TCPM_AVG_DEPTH; i++) begin
        hist[i] <= `TCPM_RESULT_RESET;
      end
    end else begin
      current_updated_out <= cur_tick;
      if (cur_tick) begin
        current_result_out <= sat_cur(current_sense_input_raw_in);
        hist[wr_idx] <= sat_cur(current_sense_input_raw_in);
        wr_idx <= wr_idx + 3'h1;
      end
    end
  end

  always_comb begin
    hist_sum = 19'sh00000;
    for (int i = 0; i < `TCPM_AVG_DEPTH; i++) begin
      hist_sum = hist_sum + 19'(signed'(hist[i]));
    end
  end

  // averaging waits one cycle so the newest current is already in the history
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avg_due <= 1'b0;
      average_current_result_out <= `TCPM_RESULT_RESET;
      average_updated_out <= 1'b0;
    end else begin
      avg_due <= cur_tick && (avg_cnt == 3'(`TCPM_AVG_PER_CUR - 1));
      average_updated_out <= avg_due;
      if (avg_due) begin
        average_current_result_out <= hist_sum[`TCPM_AVG_SHIFT +: 16];
      end
    end
  end
endmodule

// [sim/tcpm_far_side.sv]
// far-side model: charger, load and pack terminal comparators
// assumes test current enables and the discharge gate from the protector
`timescale 1ns/100ps
module tcpm_far_side (
  // clock
  input wire logic ref_clk_in,
  // scenario controls
  input wire logic charger_on_in,
  input wire logic load_short_in,
  input wire logic slow_in,
  // protector outputs
  input wire logic pulldown_en_in,
  input wire logic pullup_en_in,
  input wire logic discharge_gate_in,
  // pack comparators: charger, below margin, above margin
  output logic [2:0] pack_cmp_out
);
  logic [2:0] now_cmp;
  logic [2:0] lag_cmp;
  // charger lifts the pack above the upper tap
  assign now_cmp[0] = charger_on_in;
  // pulldown cannot win against a live charger
  assign now_cmp[1] = !charger_on_in && (pulldown_en_in || !discharge_gate_in);
  // pullup cannot win against a standing short
  assign now_cmp[2] = charger_on_in || (pullup_en_in && !load_short_in);
  always_ff @(posedge ref_clk_in) begin
    lag_cmp <= now_cmp;
  end
  // slow mode answers one cycle late
  assign pack_cmp_out = slow_in ? lag_cmp : now_cmp;
endmodule

// [sim/tcpm_protector_sva.sv]
// concurrent checks on the protector top ports
// assumes binding into tcpm_protector with its timing parameters
`timescale 1ns/100ps
module tcpm_protector_sva #(
  parameter int unsigned MEAS_CYC = 20,
  parameter int unsigned OC_DELAY_CYC = 4
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // inputs
  input wire tcpm_pkg::tcpm_cmp_t cmp_pins_in,
  input wire logic low_voltage_sleep_enable_in,
  input wire logic charge_gate_block_in,
  input wire logic discharge_gate_block_in,
  // outputs
  input wire logic charge_fet_gate_out,
  input wire logic discharge_fet_gate_out,
  input wire logic pack_pulldown_test_current_en_out,
  input wire logic pack_pullup_test_current_en_out,
  input wire logic sleep_request_out,
  input wire logic cell_high_voltage_fault_out,
  input wire logic cell_low_voltage_fault_out,
  input wire logic charge_overcurrent_fault_out,
  input wire logic discharge_overcurrent_fault_out,
  input wire logic short_circuit_fault_out,
  input wire tcpm_pkg::tcpm_word_t lower_cell_voltage_result_out,
  input wire logic current_updated_out,
  input wire logic average_updated_out
);
  import tcpm_pkg::*;
  int unsigned meas_cnt;
  int unsigned coc_run;
  logic [2:0] cur_n;
  // time base copy, paused while sleep is requested
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meas_cnt <= 0;
    end else if (!sleep_request_out) begin
      meas_cnt <= (meas_cnt == MEAS_CYC - 1) ? 0 : meas_cnt + 1;
    end
  end
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      coc_run <= 0;
      cur_n <= 3'h0;
    end else begin
      coc_run <= cmp_pins_in[6] ? coc_run + 1 : 0;
      cur_n <= cur_n + 3'(current_updated_out);
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_eighth_cur;
    current_updated_out && cur_n == 3'h7;
  endsequence
  a_chg_gate_safe: assert property (
    charge_fet_gate_out |-> !cell_high_voltage_fault_out && !cell_low_voltage_fault_out
    && !charge_overcurrent_fault_out && !$past(charge_gate_block_in)) else $error("charge gate on when not allowed");
  a_dsg_gate_safe: assert property (
    discharge_fet_gate_out |-> !cell_low_voltage_fault_out && !charge_overcurrent_fault_out
    && !discharge_overcurrent_fault_out && !short_circuit_fault_out && !$past(discharge_gate_block_in))
    else $error("discharge gate on when not allowed");
  a_pulldown_coc: assert property (
    pack_pulldown_test_current_en_out == charge_overcurrent_fault_out) else $error("pulldown mismatch");
  a_pullup_dsg: assert property (
    pack_pullup_test_current_en_out == (discharge_overcurrent_fault_out || short_circuit_fault_out))
    else $error("pullup mismatch");
  a_sleep_gated: assert property (
    sleep_request_out |-> cell_low_voltage_fault_out && $past(low_voltage_sleep_enable_in)
    && !charge_fet_gate_out && !discharge_fet_gate_out) else $error("sleep without its cause");
  a_coc_release: assert property (
    $fell(charge_overcurrent_fault_out) |-> $past(cmp_pins_in[10], 4)) else $error("charge fault left early");
  a_coc_qualify: assert property (
    $rose(charge_overcurrent_fault_out) |-> $past(coc_run, 4) >= OC_DELAY_CYC) else $error("charge fault too soon");
  a_volt_tick: assert property (
    $changed(lower_cell_voltage_result_out) |-> meas_cnt == 0) else $error("voltage off its tick");
  a_avg_eighth: assert property (
    s_eighth_cur |=> average_updated_out) else $error("average update missing");
endmodule
bind tcpm_protector tcpm_protector_sva #(
  .MEAS_CYC(MEAS_CYC),
  .OC_DELAY_CYC(OC_DELAY_CYC)
) tcpm_protector_sva_inst (.*);

// [sim/tcpm_protector_bench.sv]
// self-checking bench for the two-cell protector
// assumes shortened delay and measurement parameters
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tcpm_protector_bench;
  import tcpm_pkg::*;
  localparam int MEAS = 20;
  localparam int HV = 4;
  localparam int LV = 4;
  localparam int OC = 4;
  localparam int SC = 3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] pins = 9'h000;
  logic slp_en = 1'b0, cblk = 1'b0, dblk = 1'b0, chg_on = 1'b0, shrt = 1'b0, slow = 1'b0;
  tcpm_volt_raw_t lo_r = 13'h0000, up_r = 13'h0000;
  tcpm_temp_raw_t t_r = 11'h000;
  tcpm_cur_raw_t c_r = 18'h00000;
  tcpm_volt_raw_t vcor [4] = '{13'h0400, 13'h1BFF, 13'h03FF, 13'h1C00};
  tcpm_cur_raw_t ccor [4] = '{18'h08000, 18'h37FFF, 18'h07FFF, 18'h38000};
  logic chg, dsg, rcv, pd, pu, slp, hv, lv, charge_overcurrent_fault, discharge_overcurrent_fault, sc, cu, au;
  tcpm_word_t lo_v, up_v, tmp, cur, avg;
  logic [2:0] far;
  int n_errors = 0, checked = 0, cycles = 0, sum = 0, n;
  tcpm_protector #(.MEAS_CYC(MEAS), .HV_DELAY_CYC(HV), .LV_DELAY_CYC(LV), .OC_DELAY_CYC(OC), .SC_DELAY_CYC(SC))
  tcpm_protector_inst (.ref_clk_in(clk), .sys_rst_in(rst), .cmp_pins_in({far, pins}),
    .low_voltage_sleep_enable_in(slp_en), .charge_gate_block_in(cblk), .discharge_gate_block_in(dblk),
    .lower_cell_tap_raw_in(lo_r), .upper_cell_tap_raw_in(up_r), .temperature_raw_in(t_r),
    .current_sense_input_raw_in(c_r), .charge_fet_gate_out(chg), .discharge_fet_gate_out(dsg),
    .recovery_charge_current_en_out(rcv), .pack_pulldown_test_current_en_out(pd),
    .pack_pullup_test_current_en_out(pu), .sleep_request_out(slp), .cell_high_voltage_fault_out(hv),
    .cell_low_voltage_fault_out(lv), .charge_overcurrent_fault_out(charge_overcurrent_fault), .discharge_overcurrent_fault_out(discharge_overcurrent_fault),
    .short_circuit_fault_out(sc), .lower_cell_voltage_result_out(lo_v), .upper_cell_voltage_result_out(up_v),
    .temperature_result_out(tmp), .current_result_out(cur), .average_current_result_out(avg),
    .current_updated_out(cu), .average_updated_out(au));
  tcpm_far_side tcpm_far_side_inst (.ref_clk_in(clk), .charger_on_in(chg_on), .load_short_in(shrt),
    .slow_in(slow), .pulldown_en_in(pd), .pullup_en_in(pu), .discharge_gate_in(dsg), .pack_cmp_out(far));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic tcpm_word_t vexp(input tcpm_volt_raw_t r);
    if (r > 13'sh03FF) return 16'h7FE0;
    if (r < -13'sh0400) return 16'h8000;
    return {r[10:0], 5'h00};
  endfunction
  function automatic tcpm_word_t cexp(input tcpm_cur_raw_t r);
    if (r > 18'sh07FFF) return 16'h7FFF;
    if (r < -18'sh08000) return 16'h8000;
    return r[15:0];
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pin(input int b, input logic v, input int k);
    @(posedge clk);
    pins[b] <= v;
    cyc(k);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // generous ceiling, the whole run needs under 2500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(6));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(6);
    `CHK({chg, dsg, hv, lv, charge_overcurrent_fault, discharge_overcurrent_fault, sc}, 7'h60)
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      {cblk, dblk} <= k[1:0];
      cyc(3);
      `CHK({chg, dsg}, ~k[1:0])
    end
    @(posedge clk);
    chg_on <= 1'b1;
    // pulses lasting exactly the delay must never qualify
    repeat (3) begin
      pin(6, 1'b1, OC - 1);
      pin(6, 1'b0, 3);
    end
    `CHK(charge_overcurrent_fault, 1'b0)
    pin(6, 1'b1, OC + 8);
    pin(6, 1'b0, 8);
    `CHK({charge_overcurrent_fault, pd, chg, dsg}, 4'hC)
    @(posedge clk);
    chg_on <= 1'b0;
    cyc(8);
    `CHK({charge_overcurrent_fault, pd, chg, dsg}, 4'h3)
    for (int k = 7; k < 9; k++) begin
      @(posedge clk);
      shrt <= 1'b1;
      slow <= k[0];
      pin(k, 1'b1, (k == 7 ? OC : SC) + 8);
      pin(k, 1'b0, 8);
      `CHK({discharge_overcurrent_fault, sc, pu, chg, dsg}, {k == 7, k == 8, 3'h6})
      @(posedge clk);
      shrt <= 1'b0;
      cyc(10);
      `CHK({discharge_overcurrent_fault, sc, pu, dsg}, 4'h1)
    end
    for (int k = 0; k < 2; k++) begin
      pin(0, 1'b1, HV + 8);
      pin(0, 1'b0, 8);
      `CHK({hv, chg, dsg}, 3'h5)
      pin(k ? 3 : 5, 1'b1, 6);
      `CHK({hv, chg}, 2'h1)
      pin(k ? 3 : 5, 1'b0, 2);
    end
    @(posedge clk);
    chg_on <= 1'b1;
    pins[3] <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pin(4, k[0], 5);
      `CHK(rcv, k[0])
    end
    @(posedge clk);
    chg_on <= 1'b0;
    pins[4:2] <= 3'h0;
    pin(1, 1'b1, LV + 8);
    pin(1, 1'b0, 8);
    `CHK({lv, slp, chg, dsg}, 4'h8)
    pin(2, 1'b1, 6);
    `CHK({lv, chg, dsg}, 3'h3)
    @(posedge clk);
    slp_en <= 1'b1;
    pins[2] <= 1'b0;
    pin(1, 1'b1, LV + 8);
    `CHK({lv, slp}, 2'h3)
    pin(1, 1'b0, 0);
    @(posedge clk);
    chg_on <= 1'b1;
    cyc(6);
    `CHK({lv, slp, chg}, 3'h4)
    pin(2, 1'b1, 6);
    `CHK({lv, chg, dsg}, 3'h3)
    @(posedge clk);
    rst <= 1'b1;
    chg_on <= 1'b0;
    slp_en <= 1'b0;
    pins <= 9'h000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      lo_r <= k < 4 ? vcor[k] : 13'($urandom);
      up_r <= k < 4 ? vcor[3 - k] : 13'($urandom);
      t_r <= 11'($urandom);
      c_r <= k < 4 ? ccor[k] : 18'($urandom);
      cyc(1);
      for (n = 0; n < 400 && cu !== 1'b1; n++) begin
        cyc(1);
      end
      `CHK(cur, cexp(c_r))
      `CHK({lo_v, up_v, tmp}, {vexp(lo_r), vexp(up_r), t_r, 5'h00})
      sum += int'($signed(cexp(c_r)));
    end
    cyc(1);
    `CHK({au, avg}, {1'b1, 16'(sum >>> 3)})
    conclude();
  end
endmodule
